// file: common/axis_flags_params.svh
// Purpose: offsets, field positions and reset values of the status flag block
// Assumes: included by the flag block only
// Notes: offsets are byte addresses on the register bus
`ifndef AXIS_FLAGS_PARAMS_SVH
`define AXIS_FLAGS_PARAMS_SVH
// =============================================================
// register offsets
`define OFF_CFG 8'h00
`define OFF_WIN 8'h04
`define OFF_LUBE 8'h08
`define OFF_TOL 8'h0C
`define OFF_SPEED 8'h10
`define OFF_SYNCW 8'h14
`define OFF_STAT0 8'h18
`define OFF_STAT1 8'h1C
// =============================================================
// field positions of the configuration word
`define CFG_IDX_LSB 0
`define CFG_GANTRY_LSB 4
`define CFG_ABS_LSB 8
`define CFG_INDEP_LSB 16
// =============================================================
// reset values
`define RST_POS_WIN 16'h0010
`define RST_SETTLE 16'h0004
`define RST_LUBE_DIST 16'hFFFF
`define RST_GANTRY_LIM 16'h0100
`define RST_TOL 16'h0008
`define RST_UP_PCT 8'h6E
`define RST_LO_PCT 8'h5A
`define RST_POS_LOCK 16'h0020
`define RST_VEL_LOCK 16'h0020
`endif

// file: common/axis_flags_pkg.sv
// Purpose: types shared by the status flag block and its bench
// Assumes: four units, units 2 and 3 are the spindles
// Notes: all flags active high
package axis_flags_pkg;
   // =============================================================
   // modes and phases
   typedef enum logic [1:0] {
      ABS_NONE = 2'h0,
      ABS_TOTAL = 2'h1,
      ABS_ONE_TURN = 2'h2
   } abs_mode_t;
   typedef enum logic [1:0] {
      SPIN_STOP = 2'h0,
      SPIN_CW = 2'h1,
      SPIN_CCW = 2'h2,
      SPIN_CLOSED = 2'h3
   } spin_mode_t;
   typedef enum logic [1:0] {
      PH_BOOT = 2'b01,
      PH_RUN = 2'b10
   } phase_t;
   // =============================================================
   // per-unit and per-spindle carriers
   typedef struct packed {
      logic cmd_move;
      logic dragged;
      logic [15:0] pos_error;
      logic normal_mode_sel;
      logic on_index_pos;
      logic [7:0] travel;
      logic lube_done;
      logic [15:0] gantry_diff;
      logic park_req;
      logic unpark_req;
      logic home_done;
      logic coord_set;
      logic home_fail;
      logic ring_fail;
      logic open_loop;
      logic fb_alarm;
      logic prev_homed;
      logic pos_restored;
      logic [15:0] enc_diff;
      logic param_switch;
      logic param_valid;
      logic tang_activate;
      logic tang_stop;
   } unit_in_t;
   typedef struct packed {
      spin_mode_t mode;
      logic [2:0] cnc_gear;
      logic [5:0] plc_gear_sel;
      logic [15:0] actual_speed;
      logic [15:0] prog_speed;
      logic sync_start;
      logic sync_stop;
      logic sync_pos_mode;
      logic sync_reached;
      logic [15:0] sync_pos_err;
      logic [15:0] sync_vel_err;
      logic external_spindle_ctrl;
      logic inhibit_in;
      logic spindle_reverse_input;
   } spin_in_t;
   typedef struct packed {
      logic move_req;
      logic axis_in_position;
      logic indexed_mode_active;
      logic index_match;
      logic lube_request;
      logic gantry_diff_alarm;
      logic parked;
      logic unparked;
      logic axis_homed;
      logic param_set_changing;
      logic tangential_ctrl_on;
   } unit_flags_t;
   typedef struct packed {
      logic gear_agreement;
      logic speed_in_range;
      logic slave_sync_started;
      logic master_sync_started;
      logic slave_pos_locked;
      logic slave_vel_locked;
   } spin_flags_t;
   typedef struct packed {
      logic ext_ctrl_ok;
      logic inhibit_ok;
      logic reverse_ok;
   } spin_gate_t;
endpackage

// file: rtl/axis_spindle_status_flags.sv
// Purpose: axis and spindle status flags for the logic controller
// Assumes: one clock, flags advance on scan_strobe
// Notes: configuration and flag readback over APB, zero wait states
// Function
// RQ1 - motion request held until in position
// RQ2 - feed hold never clears motion request
// RQ3 - dragged slave also gets motion request
// RQ4 - indexed flag unless normal mode selected
// RQ5 - in position only after settle, no request
// RQ6 - channel flag ANDs non-independent in-position
// RQ7 - lube request after configured travel distance
// RQ8 - index match only on permitted position
// RQ9 - gantry alarm when difference exceeds limit
// RQ10 - parked flag, drive and feedback ignored
// RQ11 - unparked flag, control resumes
// RQ12 - full absolute keeps homed always high
// RQ13 - single-turn homed from restored saved position
// RQ14 - non-absolute homed by search or coordinate set
// RQ15 - non-absolute homed cleared by fault events
// RQ16 - parameter change flag until validation
// RQ17 - tangential flag set on activate, cleared stop
// RQ18 - gear agreement flag, no action on mismatch
// RQ19 - speed in range between percentage limits
// RQ20 - stop keeps range high, closed uses position
// RQ21 - sync flags both spindles, gates their inputs
// RQ22 - lock flags set reached, cleared window exceeded
// RQ23 - registered flags, one update per scan
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`include "axis_flags_params.svh"
`timescale 1ns/1ns
`default_nettype none
module axis_spindle_status_flags
   import axis_flags_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scan_strobe,
   input wire unit_in_t [3:0] uin,
   input wire spin_in_t [1:0] sin,
   output unit_flags_t [3:0] unit_flags,
   output spin_flags_t [1:0] spin_flags,
   output spin_gate_t [1:0] spin_gates,
   output logic channel_all_in_position
);
   typedef struct packed {
      phase_t phase;
      logic [3:0] indexable;
      logic [3:0] gantry_pair;
      logic [7:0] abs_mode;
      logic [3:0] independent;
      logic [15:0] position_window_cfg;
      logic [15:0] settle_time_cfg;
      logic [15:0] lube_distance_cfg;
      logic [15:0] gantry_limit_cfg;
      logic [15:0] restore_tolerance_cfg;
      logic [7:0] upper_speed_pct_cfg;
      logic [7:0] lower_speed_pct_cfg;
      logic [15:0] pos_lock_window_cfg;
      logic [15:0] vel_lock_window_cfg;
      logic [3:0][15:0] settle_cnt;
      logic [3:0][15:0] lube_acc;
      unit_flags_t [3:0] uf;
      spin_flags_t [1:0] sf;
      spin_gate_t [1:0] gate;
      logic chan_all;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;

   state_t r;
   state_t n;

   // =============================================================
   // next state
   always_comb begin
      logic [31:0] stat0;
      logic [31:0] stat1;
      logic [31:0] rd;
      logic hit;
      logic boot;
      logic live;
      logic win_ok;
      logic settled;
      logic [3:0] sync_mv;
      logic [16:0] sum;
      logic [23:0] act100;
      logic [23:0] lo_lim;
      logic [23:0] up_lim;
      logic synced;
      abs_mode_t am;
      stat0 = '0;
      stat1 = '0;
      rd = '0;
      hit = 1'b1;
      boot = 1'b0;
      live = 1'b0;
      win_ok = 1'b0;
      settled = 1'b0;
      sync_mv = '0;
      sum = '0;
      act100 = '0;
      lo_lim = '0;
      up_lim = '0;
      synced = 1'b0;
      am = ABS_NONE;
      n = r;
      // flag readback words
      for (int i = 0; i < 4; i++) begin
         stat0[i] = r.uf[i].move_req;
         stat0[4+i] = r.uf[i].axis_in_position;
         stat0[8+i] = r.uf[i].indexed_mode_active;
         stat0[12+i] = r.uf[i].index_match;
         stat0[16+i] = r.uf[i].lube_request;
         stat0[20+i] = r.uf[i].gantry_diff_alarm;
         stat0[24+i] = r.uf[i].parked;
         stat0[28+i] = r.uf[i].unparked;
         stat1[i] = r.uf[i].axis_homed;
         stat1[4+i] = r.uf[i].param_set_changing;
         stat1[8+i] = r.uf[i].tangential_ctrl_on;
      end
      for (int s = 0; s < 2; s++) begin
         stat1[12+s] = r.sf[s].gear_agreement;
         stat1[14+s] = r.sf[s].speed_in_range;
         stat1[16+s] = r.sf[s].slave_sync_started;
         stat1[18+s] = r.sf[s].master_sync_started;
         stat1[20+s] = r.sf[s].slave_pos_locked;
         stat1[22+s] = r.sf[s].slave_vel_locked;
      end
      stat1[24] = r.chan_all;
      // =============================================================
      // register bus
      if (paddr == `OFF_CFG) begin
         rd = {12'h000, r.independent, r.abs_mode, r.gantry_pair,
               r.indexable};
      end else if (paddr == `OFF_WIN) begin
         rd = {r.settle_time_cfg, r.position_window_cfg};
      end else if (paddr == `OFF_LUBE) begin
         rd = {r.gantry_limit_cfg, r.lube_distance_cfg};
      end else if (paddr == `OFF_TOL) begin
         rd = {16'h0000, r.restore_tolerance_cfg};
      end else if (paddr == `OFF_SPEED) begin
         rd = {16'h0000, r.lower_speed_pct_cfg, r.upper_speed_pct_cfg};
      end else if (paddr == `OFF_SYNCW) begin
         rd = {r.vel_lock_window_cfg, r.pos_lock_window_cfg};
      end else if (paddr == `OFF_STAT0) begin
         rd = stat0;
      end else if (paddr == `OFF_STAT1) begin
         rd = stat1;
      end else begin
         hit = 1'b0;
      end
      n.pready = 1'b0;
      if (psel && !penable) begin
         n.pready = 1'b1;
         n.pslverr = !hit;
         n.prdata = pwrite ? 32'h0000_0000 : rd;
      end
      if (psel && penable && r.pready && pwrite && !r.pslverr) begin
         if (paddr == `OFF_CFG) begin
            n.indexable = pwdata[`CFG_IDX_LSB +: 4];
            n.gantry_pair = pwdata[`CFG_GANTRY_LSB +: 4];
            n.abs_mode = pwdata[`CFG_ABS_LSB +: 8];
            n.independent = pwdata[`CFG_INDEP_LSB +: 4];
         end else if (paddr == `OFF_WIN) begin
            n.position_window_cfg = pwdata[15:0];
            n.settle_time_cfg = pwdata[31:16];
         end else if (paddr == `OFF_LUBE) begin
            n.lube_distance_cfg = pwdata[15:0];
            n.gantry_limit_cfg = pwdata[31:16];
         end else if (paddr == `OFF_TOL) begin
            n.restore_tolerance_cfg = pwdata[15:0];
         end else if (paddr == `OFF_SPEED) begin
            n.upper_speed_pct_cfg = pwdata[7:0];
            n.lower_speed_pct_cfg = pwdata[15:8];
         end else if (paddr == `OFF_SYNCW) begin
            n.pos_lock_window_cfg = pwdata[15:0];
            n.vel_lock_window_cfg = pwdata[31:16];
         end
      end
      // =============================================================
      // flags, once per scan
      case (r.phase)
         PH_BOOT: boot = 1'b1;
         PH_RUN: boot = 1'b0;
         default: boot = 1'b1;
      endcase
      if (scan_strobe) begin // RQ23
         n.phase = PH_RUN;
         for (int s = 0; s < 2; s++) begin
            sync_mv[2+s] = sin[s].sync_start | sin[1-s].sync_start; // RQ21
         end
         for (int i = 0; i < 4; i++) begin
            live = !r.uf[i].parked; // RQ10
            win_ok = live && (uin[i].pos_error <= r.position_window_cfg);
            settled = win_ok && (r.settle_cnt[i] >= r.settle_time_cfg);
            n.settle_cnt[i] = !win_ok ? 16'h0000 :
               (r.settle_cnt[i] == 16'hFFFF) ? r.settle_cnt[i] :
               r.settle_cnt[i] + 16'h0001;
            // feed hold is deliberately not a clearing term
            n.uf[i].move_req = (live & (uin[i].cmd_move | uin[i].dragged))
               | sync_mv[i] | (r.uf[i].move_req & !settled); // RQ1 RQ2 RQ3
            n.uf[i].axis_in_position = settled & !n.uf[i].move_req; // RQ5
            n.uf[i].indexed_mode_active = r.indexable[i]
               & !uin[i].normal_mode_sel; // RQ4
            n.uf[i].index_match = r.indexable[i] & live
               & uin[i].on_index_pos; // RQ8
            sum = {1'b0, uin[i].lube_done ? 16'h0000 : r.lube_acc[i]}
               + {9'h000, live ? uin[i].travel : 8'h00};
            n.lube_acc[i] = sum[16] ? 16'hFFFF : sum[15:0];
            n.uf[i].lube_request = (n.lube_acc[i] >= r.lube_distance_cfg)
               | (r.uf[i].lube_request & !uin[i].lube_done); // RQ7
            n.uf[i].gantry_diff_alarm = r.gantry_pair[i] & live
               & (uin[i].gantry_diff > r.gantry_limit_cfg); // RQ9
            if (uin[i].park_req) begin
               n.uf[i].parked = 1'b1; // RQ10
               n.uf[i].unparked = 1'b0;
            end else if (uin[i].unpark_req) begin
               n.uf[i].parked = 1'b0; // RQ11
               n.uf[i].unparked = 1'b1;
            end
            am = abs_mode_t'(r.abs_mode[2*i +: 2]);
            case (am)
               ABS_TOTAL: n.uf[i].axis_homed = 1'b1; // RQ12
               ABS_ONE_TURN: n.uf[i].axis_homed = boot ?
                  (uin[i].prev_homed & uin[i].pos_restored
                   & (uin[i].enc_diff < r.restore_tolerance_cfg)) :
                  (r.uf[i].axis_homed | (live & uin[i].home_done)); // RQ13
               default: n.uf[i].axis_homed = !boot & ((live
                  & (uin[i].home_done | uin[i].coord_set)) // RQ14
                  | (r.uf[i].axis_homed & !(uin[i].home_fail
                  | uin[i].park_req | uin[i].ring_fail
                  | uin[i].open_loop | uin[i].fb_alarm))); // RQ15
            endcase
            n.uf[i].param_set_changing = uin[i].param_switch
               | (r.uf[i].param_set_changing & !uin[i].param_valid); // RQ16
            n.uf[i].tangential_ctrl_on = uin[i].tang_activate
               | (r.uf[i].tangential_ctrl_on & !uin[i].tang_stop); // RQ17
         end
         for (int s = 0; s < 2; s++) begin
            n.sf[s].gear_agreement = (sin[s].cnc_gear != 3'h0)
               && (sin[s].cnc_gear <= 3'h6) && (sin[s].plc_gear_sel
               == (6'h01 << (sin[s].cnc_gear - 3'h1))); // RQ18
            act100 = 24'(sin[s].actual_speed) * 24'h000064;
            lo_lim = 24'(sin[s].prog_speed) * 24'(r.lower_speed_pct_cfg);
            up_lim = 24'(sin[s].prog_speed) * 24'(r.upper_speed_pct_cfg);
            case (sin[s].mode)
               SPIN_STOP: n.sf[s].speed_in_range = 1'b1; // RQ20
               SPIN_CLOSED: n.sf[s].speed_in_range =
                  n.uf[2+s].axis_in_position; // RQ20
               default: n.sf[s].speed_in_range = (act100 >= lo_lim)
                  && (act100 <= up_lim); // RQ19
            endcase
            n.sf[s].slave_sync_started = sin[s].sync_start
               | (r.sf[s].slave_sync_started & !sin[s].sync_stop); // RQ21
            n.sf[s].master_sync_started = sin[1-s].sync_start
               | (r.sf[s].master_sync_started & !sin[1-s].sync_stop);
            n.sf[s].slave_pos_locked = n.sf[s].slave_sync_started
               & sin[s].sync_pos_mode
               & (sin[s].sync_reached | r.sf[s].slave_pos_locked)
               & (sin[s].sync_pos_err <= r.pos_lock_window_cfg); // RQ22
            n.sf[s].slave_vel_locked = n.sf[s].slave_sync_started
               & !sin[s].sync_pos_mode
               & (sin[s].sync_reached | r.sf[s].slave_vel_locked)
               & (sin[s].sync_vel_err <= r.vel_lock_window_cfg); // RQ22
            synced = n.sf[s].slave_sync_started
               | n.sf[s].master_sync_started;
            n.gate[s].ext_ctrl_ok = sin[s].external_spindle_ctrl
               & !synced; // RQ21
            n.gate[s].inhibit_ok = sin[s].inhibit_in & !synced;
            n.gate[s].reverse_ok = sin[s].spindle_reverse_input & !synced;
         end
         n.chan_all = 1'b1;
         for (int i = 0; i < 4; i++) begin
            n.chan_all = n.chan_all & (n.uf[i].axis_in_position
               | r.independent[i]); // RQ6
         end
      end
   end

   // =============================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.phase <= PH_BOOT;
         r.position_window_cfg <= `RST_POS_WIN;
         r.settle_time_cfg <= `RST_SETTLE;
         r.lube_distance_cfg <= `RST_LUBE_DIST;
         r.gantry_limit_cfg <= `RST_GANTRY_LIM;
         r.restore_tolerance_cfg <= `RST_TOL;
         r.upper_speed_pct_cfg <= `RST_UP_PCT;
         r.lower_speed_pct_cfg <= `RST_LO_PCT;
         r.pos_lock_window_cfg <= `RST_POS_LOCK;
         r.vel_lock_window_cfg <= `RST_VEL_LOCK;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign unit_flags = r.uf;
   assign spin_flags = r.sf;
   assign spin_gates = r.gate;
   assign channel_all_in_position = r.chan_all;

   // =============================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence park_ev;
      scan_strobe && uin[0].park_req;
   endsequence
   sequence sync_ev;
      scan_strobe && sin[0].sync_start;
   endsequence

   move_until_pos_a: assert property ($fell(r.uf[0].move_req)
      |-> r.uf[0].axis_in_position) else $error("move fell early"); // RQ1
   axis_in_position_no_req_a: assert property (r.uf[0].axis_in_position
      |-> !r.uf[0].move_req) else $error("in position while moving"); // RQ5
   drag_move_a: assert property (scan_strobe && !r.uf[0].parked
      && uin[0].dragged |=> r.uf[0].move_req)
      else $error("dragged slave not moving"); // RQ3
   index_mode_a: assert property (scan_strobe && r.indexable[0]
      && !uin[0].normal_mode_sel |=> r.uf[0].indexed_mode_active)
      else $error("indexed mode missing"); // RQ4
   chan_and_a: assert property (scan_strobe ##1 1 |-> r.chan_all
      == &({r.uf[3].axis_in_position, r.uf[2].axis_in_position,
      r.uf[1].axis_in_position, r.uf[0].axis_in_position}
      | $past(r.independent))) else $error("channel flag wrong"); // RQ6
   gantry_alarm_a: assert property (scan_strobe && r.gantry_pair[0]
      && !r.uf[0].parked && uin[0].gantry_diff > r.gantry_limit_cfg
      |=> r.uf[0].gantry_diff_alarm) else $error("gantry alarm missing"); // RQ9
   park_state_a: assert property (park_ev |=> r.uf[0].parked
      && !r.uf[0].unparked ##1 r.uf[0].parked || scan_strobe)
      else $error("park not taken"); // RQ10
   homed_total_a: assert property (scan_strobe
      && r.abs_mode[3:2] == ABS_TOTAL |=> r.uf[1].axis_homed)
      else $error("full absolute not homed"); // RQ12
   homed_park_a: assert property ((park_ev and (r.abs_mode[1:0] == ABS_NONE
      && !uin[0].home_done && !uin[0].coord_set)) |=> !r.uf[0].axis_homed)
      else $error("homed survives park"); // RQ15
   stop_range_a: assert property (scan_strobe && sin[0].mode == SPIN_STOP
      |=> r.sf[0].speed_in_range) else $error("stop range low"); // RQ20
   sync_both_a: assert property (sync_ev |=> r.uf[2].move_req
      && r.uf[3].move_req && r.sf[0].slave_sync_started
      && r.sf[1].master_sync_started && !r.gate[0].reverse_ok
      && !r.gate[1].ext_ctrl_ok) else $error("sync start incomplete"); // RQ21
   apb_answer_a: assert property (psel && !penable |=> pready
      ##1 !pready) else $error("bus answer timing");
endmodule
`default_nettype wire

// file: tb/plc_partner_model.sv
// Purpose: logic controller stand-in facing the status flag block
// Assumes: gear code 1..6 picks one bit of the gear select
// Notes: behavioural
`timescale 1ns/1ns
`default_nettype none
module plc_partner_model
   import axis_flags_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] gear_code,
   input wire unit_flags_t [3:0] unit_flags,
   output logic [5:0] plc_gear_sel,
   output logic [3:0] axis_enable
);
   // =============================================================
   // gear request and axis enable
   assign plc_gear_sel = (gear_code != 3'h0) ?
      (6'h01 << (gear_code - 3'h1)) : 6'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         axis_enable <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            axis_enable[i] <= !unit_flags[i].param_set_changing;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/test_axis_spindle_status_flags.sv
// Purpose: self-checking bench of the status flag block
// Assumes: units 2 and 3 are spindles 0 and 1
// Notes: flags checked one step after each scan edge
`timescale 1ns/1ns
`default_nettype none
module test_axis_spindle_status_flags;
   import axis_flags_pkg::*;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic scan_strobe = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, chan;
   logic [2:0] gear_code = 3'h0;
   logic [5:0] gsel;
   logic [3:0] aen;
   unit_in_t [3:0] uin = '0;
   unit_in_t [3:0] u = '0;
   spin_in_t [1:0] sin = '0;
   spin_in_t [1:0] s = '0;
   unit_flags_t [3:0] uf;
   spin_flags_t [1:0] sf;
   spin_gate_t [1:0] sg;
   int num_errors = 0;
   int num_checks = 0;
   always #5 pclk = ~pclk;
   // =============================================================
   // design and partner
   axis_spindle_status_flags i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scan_strobe(scan_strobe), .uin(uin),
      .sin(sin), .unit_flags(uf), .spin_flags(sf), .spin_gates(sg),
      .channel_all_in_position(chan));
   plc_partner_model i_plc (.pclk(pclk), .presetn(presetn),
      .gear_code(gear_code), .unit_flags(uf), .plc_gear_sel(gsel),
      .axis_enable(aen));
   // =============================================================
   // tasks
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic scan();
      @(posedge pclk);
      s[0].plc_gear_sel = gsel;
      uin <= u;
      sin <= s;
      scan_strobe <= 1'h1;
      @(posedge pclk);
      scan_strobe <= 1'h0;
      #1;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // =============================================================
   // watchdog
   initial begin
      #100000;
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      close_out();
   end
   // =============================================================
   // tests
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h1, 8'h00, 32'h0000A411);
      apb(1'h1, 8'h08, 32'h0100000A);
      apb(1'h0, 8'h20, 32'h0);
      ck(err, 1'h1);
      for (int i = 0; i < 4; i++) begin
         u[i].cmd_move = (i != 1);
         u[i].pos_error = 16'h0100;
      end
      u[1].dragged = 1'h1;
      u[2].prev_homed = 1'h1;
      u[2].pos_restored = 1'h1;
      u[2].enc_diff = 16'h0003;
      u[3].prev_homed = 1'h1;
      u[3].pos_restored = 1'h1;
      u[3].enc_diff = 16'h0009;
      scan();
      ck(uf[1].move_req, 1'h1);
      ck({uf[3].axis_homed, uf[2].axis_homed, uf[1].axis_homed,
         uf[0].axis_homed}, 4'h6);
      for (int i = 0; i < 4; i++) begin
         u[i].cmd_move = 1'h0;
         u[i].dragged = 1'h0;
         u[i].pos_error = 16'h0005;
      end
      repeat (4) scan();
      ck(uf[0].move_req, 1'h1);
      ck(chan, 1'h0);
      scan();
      ck(uf[0].move_req, 1'h0);
      ck(chan, 1'h1);
      apb(1'h0, 8'h18, 32'h0);
      ck(rd, 32'h000001F0);
      u[0].on_index_pos = 1'h1;
      u[0].travel = 8'h06;
      u[0].gantry_diff = 16'h0100;
      scan();
      ck(uf[0].index_match, 1'h1);
      ck(uf[0].lube_request, 1'h0);
      ck(uf[0].gantry_diff_alarm, 1'h0);
      u[0].normal_mode_sel = 1'h1;
      u[0].gantry_diff = 16'h0101;
      scan();
      ck(uf[0].indexed_mode_active, 1'h0);
      ck(uf[0].lube_request, 1'h1);
      ck(uf[0].gantry_diff_alarm, 1'h1);
      u[0].travel = 8'h00;
      u[0].home_done = 1'h1;
      scan();
      ck(uf[0].axis_homed, 1'h1);
      u[0].home_done = 1'h0;
      u[0].park_req = 1'h1;
      scan();
      ck(uf[0].parked, 1'h1);
      ck(uf[0].axis_homed, 1'h0);
      u[0].park_req = 1'h0;
      u[0].cmd_move = 1'h1;
      scan();
      ck(uf[0].move_req, 1'h0);
      u[0].cmd_move = 1'h0;
      u[0].unpark_req = 1'h1;
      scan();
      ck(uf[0].unparked, 1'h1);
      u[1].tang_activate = 1'h1;
      u[1].param_switch = 1'h1;
      scan();
      ck(uf[1].tangential_ctrl_on, 1'h1);
      ck(uf[1].param_set_changing, 1'h1);
      u[1].tang_activate = 1'h0;
      u[1].param_switch = 1'h0;
      u[1].tang_stop = 1'h1;
      u[1].param_valid = 1'h1;
      scan();
      ck(uf[1].tangential_ctrl_on, 1'h0);
      ck(uf[1].param_set_changing, 1'h0);
      ck(aen[1], 1'h0);
      s[0].cnc_gear = 3'h1;
      gear_code = 3'h1;
      scan();
      ck(sf[0].gear_agreement, 1'h1);
      ck(aen[1], 1'h1);
      gear_code = 3'h2;
      s[0].mode = SPIN_CW;
      s[0].prog_speed = 16'h03E8;
      s[0].actual_speed = 16'h044C;
      scan();
      ck(sf[0].gear_agreement, 1'h0);
      ck(sf[0].speed_in_range, 1'h1);
      s[0].actual_speed = 16'h044D;
      scan();
      ck(sf[0].speed_in_range, 1'h0);
      s[0].mode = SPIN_STOP;
      s[1].external_spindle_ctrl = 1'h1;
      scan();
      ck(sf[0].speed_in_range, 1'h1);
      ck(sg[1].ext_ctrl_ok, 1'h1);
      s[0].sync_start = 1'h1;
      s[0].sync_pos_mode = 1'h1;
      scan();
      ck(sf[0].slave_sync_started, 1'h1);
      ck(sf[1].master_sync_started, 1'h1);
      ck(sg[1].ext_ctrl_ok, 1'h0);
      ck(uf[3].move_req, 1'h1);
      s[0].sync_start = 1'h0;
      s[0].sync_reached = 1'h1;
      scan();
      ck(sf[0].slave_pos_locked, 1'h1);
      s[0].sync_reached = 1'h0;
      s[0].sync_pos_err = 16'h0021;
      scan();
      ck(sf[0].slave_pos_locked, 1'h0);
      s[0].sync_pos_mode = 1'h0;
      s[0].sync_reached = 1'h1;
      s[0].spindle_reverse_input = 1'h1;
      s[1].inhibit_in = 1'h1;
      scan();
      ck(sf[0].slave_vel_locked, 1'h1);
      ck({sg[1].inhibit_ok, sg[0].reverse_ok}, 2'h0);
      s[0].sync_reached = 1'h0;
      s[0].sync_vel_err = 16'h0021;
      scan();
      ck(sf[0].slave_vel_locked, 1'h0);
      s[0].sync_stop = 1'h1;
      scan();
      ck(sf[0].slave_sync_started, 1'h0);
      ck({sg[1].inhibit_ok, sg[0].reverse_ok}, 2'h3);
      close_out();
   end
endmodule
`default_nettype wire
